//--- arit_cfg.svh
// offsets, field positions, reset values and divider taps of the timer
// assumes a 16-bit byte address on the register port
`ifndef ARIT_CFG_SVH
`define ARIT_CFG_SVH

`define ARIT_ADDR_W        16
`define ARIT_DATA_W        8
`define ARIT_MODE_ADDR     16'hFFB2
`define ARIT_COUNT_ADDR    16'hFFB3
`define ARIT_IRQ_ADDR      16'hFFB4

`define ARIT_MODE_AR_BIT   7
`define ARIT_MODE_RSV_HI   6
`define ARIT_MODE_RSV_LO   3
`define ARIT_MODE_CS_HI    2
`define ARIT_MODE_CS_LO    0
`define ARIT_MODE_RESET    8'h78
`define ARIT_MODE_RSV_VAL  4'hF

`define ARIT_IRQ_FLAG_BIT  0
`define ARIT_IRQ_EN_BIT    1
`define ARIT_IRQ_EDGE_BIT  2

`define ARIT_COUNT_RESET   8'h00
`define ARIT_LOAD_RESET    8'h00
`define ARIT_COUNT_MAX     8'hFF
`define ARIT_UNMAPPED      8'h00

`define ARIT_PRESC_W       13
`define ARIT_TAP_8192      13
`define ARIT_TAP_2048      11
`define ARIT_TAP_512       9
`define ARIT_TAP_256       8
`define ARIT_TAP_64        6
`define ARIT_TAP_16        4
`define ARIT_TAP_4         2
`define ARIT_CS_EXTERNAL   3'h7

`endif

//--- arit_pkg.sv
// types of the auto-reload interval timer
// assumes arit_cfg.svh is compiled alongside
`include "arit_cfg.svh"

package arit_pkg;

  typedef enum logic [2:0] {
    CS_DIV8192 = 3'h0,
    CS_DIV2048 = 3'h1,
    CS_DIV512  = 3'h2,
    CS_DIV256  = 3'h3,
    CS_DIV64   = 3'h4,
    CS_DIV16   = 3'h5,
    CS_DIV4    = 3'h6,
    CS_EVENT   = 3'h7
  } arit_clock_select_type;

  typedef struct packed {
    logic                  auto_reload_select;
    arit_clock_select_type clock_select;
  } arit_mode_type;

  typedef struct packed {
    logic [`ARIT_ADDR_W-1:0] addr;
    logic [`ARIT_DATA_W-1:0] wdata;
    logic                    write;
    logic                    read;
  } arit_bus_type;

  typedef struct packed {
    arit_mode_type               mode;
    logic [`ARIT_DATA_W-1:0]     count;
    logic [`ARIT_DATA_W-1:0]     reload;
    logic                        overflow_request_flag;
    logic                        overflow_interrupt_enable;
    logic                        event_edge_select;
    logic [`ARIT_PRESC_W-1:0]    prescaler;
    logic                        event_sync1;
    logic                        event_sync2;
    logic                        event_prev;
    logic [`ARIT_DATA_W-1:0]     rdata;
    logic                        irq;
  } arit_state_type;

endpackage

//--- arit_timer.sv
// 8-bit up-counting timer with interval and auto-reload modes
// assumes a single-cycle register port and an asynchronous event pin, synchronised in two flops
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "arit_cfg.svh"

module arit_timer
(
  input  wire logic                    MCLK,
  input  wire logic                    RESET,
  input  wire logic                    CLOCK_ENABLE,
  input  wire logic                    COUNT_HALT,
  input  wire logic [`ARIT_ADDR_W-1:0] BUS_ADDR,
  input  wire logic [`ARIT_DATA_W-1:0] BUS_WDATA,
  input  wire logic                    BUS_WRITE,
  input  wire logic                    BUS_READ,
  output logic      [`ARIT_DATA_W-1:0] BUS_RDATA,
  input  wire logic                    EVENT_COUNT_PIN,
  output logic                         OVERFLOW_IRQ
);

  arit_pkg::arit_state_type state;
  arit_pkg::arit_state_type next_state;
  arit_pkg::arit_bus_type   bus;

  localparam arit_pkg::arit_state_type RESET_STATE = '{
    mode:                      arit_pkg::arit_mode_type'({1'b0, 3'h0}),
    count:                     `ARIT_COUNT_RESET,
    reload:                    `ARIT_LOAD_RESET,
    overflow_request_flag:     1'b0,
    overflow_interrupt_enable: 1'b0,
    event_edge_select:         1'b0,
    prescaler:                 {`ARIT_PRESC_W{1'b0}},
    event_sync1:               1'b0,
    event_sync2:               1'b0,
    event_prev:                1'b0,
    rdata:                     `ARIT_UNMAPPED,
    irq:                       1'b0
  };

  assign bus.addr  = BUS_ADDR;
  assign bus.wdata = BUS_WDATA;
  assign bus.write = BUS_WRITE;
  assign bus.read  = BUS_READ;

  // number of low prescaler bits that must be all ones for a tick
  function automatic logic [3:0] tap_width
  (
    input arit_pkg::arit_clock_select_type sel
  );
    logic [3:0] w;
    w = 4'h0;
    unique case (sel)
      arit_pkg::CS_DIV8192: w = 4'(`ARIT_TAP_8192);
      arit_pkg::CS_DIV2048: w = 4'(`ARIT_TAP_2048);
      arit_pkg::CS_DIV512:  w = 4'(`ARIT_TAP_512);
      arit_pkg::CS_DIV256:  w = 4'(`ARIT_TAP_256);
      arit_pkg::CS_DIV64:   w = 4'(`ARIT_TAP_64);
      arit_pkg::CS_DIV16:   w = 4'(`ARIT_TAP_16);
      arit_pkg::CS_DIV4:    w = 4'(`ARIT_TAP_4);
      arit_pkg::CS_EVENT:   w = 4'h0;
    endcase
    return w;
  endfunction

  logic [`ARIT_PRESC_W-1:0] tap_mask;
  logic [`ARIT_PRESC_W-1:0] tap_hits;
  logic [3:0]               tap_len;

  assign tap_len = tap_width(state.mode.clock_select);

  // one mask bit per prescaler stage
  genvar gi;
  generate
    for (gi = 0; gi < `ARIT_PRESC_W; gi = gi + 1)
    begin : g_tap
      assign tap_mask[gi] = (4'(gi) < tap_len);
      assign tap_hits[gi] = state.prescaler[gi] | ~tap_mask[gi];
    end
  endgenerate

  logic internal_tick;
  logic event_edge;
  logic count_tick;
  logic run;
  logic write_mode;
  logic write_load;
  logic write_irq;

  always_comb
  begin
    run           = ~COUNT_HALT;
    // a tick when all selected low stages read ones, i.e. once per period
    internal_tick = run & (&tap_hits);
    // edge taken from the second stage only, never the first
    event_edge    = state.event_edge_select
                  ? (state.event_sync2 & ~state.event_prev)
                  : (~state.event_sync2 & state.event_prev);
    if (state.mode.clock_select == arit_pkg::CS_EVENT)
    begin
      count_tick = run & event_edge;
    end
    else
    begin
      count_tick = internal_tick;
    end
    write_mode = bus.write & (bus.addr == `ARIT_MODE_ADDR);
    write_load = bus.write & (bus.addr == `ARIT_COUNT_ADDR);
    write_irq  = bus.write & (bus.addr == `ARIT_IRQ_ADDR);
  end

  always_comb
  begin
    next_state = state;

    // prescaler stops with the counter in low-power modes
    if (run)
    begin
      next_state.prescaler = state.prescaler + `ARIT_PRESC_W'(1);
    end

    next_state.event_sync1 = EVENT_COUNT_PIN;
    next_state.event_sync2 = state.event_sync1;
    next_state.event_prev  = state.event_sync2;

    // reserved bits are not stored; writes to them are dropped
    if (write_mode)
    begin
      next_state.mode.auto_reload_select = bus.wdata[`ARIT_MODE_AR_BIT];
      next_state.mode.clock_select = arit_pkg::arit_clock_select_type'(
        bus.wdata[`ARIT_MODE_CS_HI:`ARIT_MODE_CS_LO]);
    end

    if (write_irq)
    begin
      next_state.overflow_request_flag =
        state.overflow_request_flag & bus.wdata[`ARIT_IRQ_FLAG_BIT];
      next_state.overflow_interrupt_enable = bus.wdata[`ARIT_IRQ_EN_BIT];
      next_state.event_edge_select = bus.wdata[`ARIT_IRQ_EDGE_BIT];
    end

    if (count_tick)
    begin
      if (state.count == `ARIT_COUNT_MAX)
      begin
        // overflow sets the flag; set beats a same-cycle software clear
        next_state.overflow_request_flag = 1'b1;
        // auto-reload copies the load value, giving 1 to 256 inputs
        if (state.mode.auto_reload_select)
        begin
          next_state.count = state.reload;
        end
        else
        begin
          next_state.count = `ARIT_COUNT_RESET;
        end
      end
      else
      begin
        next_state.count = state.count + `ARIT_DATA_W'(1);
      end
    end

    // load write wins over a same-cycle count step
    if (write_load)
    begin
      next_state.reload = bus.wdata;
      next_state.count  = bus.wdata;
    end

    // reads see the counter, never the load register
    if (bus.read)
    begin
      unique case (bus.addr)
        // reserved bits read back as ones
        `ARIT_MODE_ADDR:
        begin
          next_state.rdata = {state.mode.auto_reload_select,
                              `ARIT_MODE_RSV_VAL,
                              state.mode.clock_select};
        end
        `ARIT_COUNT_ADDR:
        begin
          next_state.rdata = state.count;
        end
        `ARIT_IRQ_ADDR:
        begin
          next_state.rdata = {5'h00,
                              state.event_edge_select,
                              state.overflow_interrupt_enable,
                              state.overflow_request_flag};
        end
        default:
        begin
          next_state.rdata = `ARIT_UNMAPPED;
        end
      endcase
    end
    else
    begin
      // read data stand for one cycle only
      next_state.rdata = `ARIT_UNMAPPED;
    end

    // enable gates the flag; registered so the output is glitch free
    next_state.irq = next_state.overflow_request_flag
                   & next_state.overflow_interrupt_enable;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      state <= RESET_STATE;
    end
    else if (CLOCK_ENABLE)
    begin
      state <= next_state;
    end
  end

  assign BUS_RDATA    = state.rdata;
  assign OVERFLOW_IRQ = state.irq;

endmodule // arit_timer

//--- arit_timer_checker.sv
// assertions on the timer's register port and interrupt output
// assumes binding onto arit_timer with arit_cfg.svh on the include path
`timescale 1ns/10ps
`include "arit_cfg.svh"

module arit_timer_checker
(
  input wire logic                    MCLK,
  input wire logic                    RESET,
  input wire logic                    CLOCK_ENABLE,
  input wire logic                    COUNT_HALT,
  input wire logic [`ARIT_ADDR_W-1:0] BUS_ADDR,
  input wire logic [`ARIT_DATA_W-1:0] BUS_WDATA,
  input wire logic                    BUS_WRITE,
  input wire logic                    BUS_READ,
  input wire logic [`ARIT_DATA_W-1:0] BUS_RDATA,
  input wire logic                    EVENT_COUNT_PIN,
  input wire logic                    OVERFLOW_IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);

  wire on_mode = BUS_ADDR == `ARIT_MODE_ADDR;
  wire on_cnt  = BUS_ADDR == `ARIT_COUNT_ADDR;
  wire on_irq  = BUS_ADDR == `ARIT_IRQ_ADDR;

  sequence s_mode_wr;
    BUS_WRITE && on_mode && CLOCK_ENABLE;
  endsequence
  sequence s_mode_rd;
    BUS_READ && on_mode && CLOCK_ENABLE;
  endsequence
  sequence s_rd_halt;
    BUS_READ && on_cnt && COUNT_HALT && CLOCK_ENABLE && !BUS_WRITE;
  endsequence

  reset_out_a: assert property (
    $past(RESET) |-> BUS_RDATA == 8'h00 && !OVERFLOW_IRQ) else $error("outputs not clear");
  rdata_idle_a: assert property (
    $past(CLOCK_ENABLE && !BUS_READ) |-> BUS_RDATA == 8'h00) else $error("read data idle");
  mode_rsv_a: assert property (
    s_mode_rd |=> BUS_RDATA[6:3] == 4'hF) else $error("reserved mode bits");
  mode_wr_a: assert property (
    s_mode_wr ##1 s_mode_rd |=> BUS_RDATA == ($past(BUS_WDATA, 2) | 8'h78))
    else $error("mode readback");
  load_rd_a: assert property (
    (BUS_WRITE && on_cnt && COUNT_HALT && CLOCK_ENABLE) ##1 s_rd_halt
    |=> BUS_RDATA == $past(BUS_WDATA, 2)) else $error("load not in counter");
  halt_hold_a: assert property (
    s_rd_halt ##1 s_rd_halt |=> BUS_RDATA == $past(BUS_RDATA)) else $error("counted in halt");
  irq_mask_a: assert property (
    (BUS_WRITE && on_irq && !BUS_WDATA[1] && CLOCK_ENABLE) ##1 CLOCK_ENABLE
    |=> !OVERFLOW_IRQ) else $error("masked interrupt");
  unmapped_a: assert property (
    $past(BUS_READ && CLOCK_ENABLE && !on_mode && !on_cnt && !on_irq)
    |-> BUS_RDATA == 8'h00) else $error("unmapped read");
endmodule // arit_timer_checker

bind arit_timer arit_timer_checker arit_timer_checker_inst
(
  .MCLK(MCLK), .RESET(RESET), .CLOCK_ENABLE(CLOCK_ENABLE), .COUNT_HALT(COUNT_HALT),
  .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WRITE(BUS_WRITE), .BUS_READ(BUS_READ),
  .BUS_RDATA(BUS_RDATA), .EVENT_COUNT_PIN(EVENT_COUNT_PIN), .OVERFLOW_IRQ(OVERFLOW_IRQ)
);

//--- tb_arit_timer.sv
// self-checking bench of the auto-reload interval timer
// assumes arit_cfg.svh on the include path and the checker bound alongside
`timescale 1ns/10ps
`include "arit_cfg.svh"

module tb_arit_timer;
  logic        MCLK = 1'b0;
  logic        RESET = 1'b1;
  logic        COUNT_HALT = 1'b0;
  logic        CLOCK_ENABLE = 1'b1;
  logic [15:0] BUS_ADDR = 16'h0000;
  logic [7:0]  BUS_WDATA = 8'h00;
  logic        BUS_WRITE = 1'b0;
  logic        BUS_READ = 1'b0;
  logic        EVENT_COUNT_PIN = 1'b0;
  logic [7:0]  BUS_RDATA;
  logic        OVERFLOW_IRQ;
  int          mismatches = 0;
  int          comparisons = 0;
  int          dv[7] = '{8192, 2048, 512, 256, 64, 16, 4};

  arit_timer arit_timer_inst
  (
    .MCLK(MCLK), .RESET(RESET), .CLOCK_ENABLE(CLOCK_ENABLE), .COUNT_HALT(COUNT_HALT),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WRITE(BUS_WRITE),
    .BUS_READ(BUS_READ), .BUS_RDATA(BUS_RDATA), .EVENT_COUNT_PIN(EVENT_COUNT_PIN),
    .OVERFLOW_IRQ(OVERFLOW_IRQ)
  );

  initial
  begin
    forever #5 MCLK = ~MCLK;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    BUS_WRITE <= 1'b1;
    @(posedge MCLK);
    BUS_WRITE <= 1'b0;
    @(posedge MCLK);
  endtask

  task rd(input logic [15:0] a, input logic [7:0] exp);
    BUS_ADDR <= a;
    BUS_READ <= 1'b1;
    @(posedge MCLK);
    BUS_READ <= 1'b0;
    #1 chk(BUS_RDATA, exp);
    @(posedge MCLK);
  endtask

  // write strobe then read strobe on the very next cycle, no gap
  task wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    BUS_WRITE <= 1'b1;
    @(posedge MCLK);
    BUS_WRITE <= 1'b0;
    BUS_READ <= 1'b1;
    @(posedge MCLK);
    BUS_READ <= 1'b0;
    #1 chk(BUS_RDATA, exp);
    @(posedge MCLK);
  endtask

  // two reads back to back; both must return the same value
  task rd2(input logic [15:0] a, input logic [7:0] exp);
    BUS_ADDR <= a;
    BUS_READ <= 1'b1;
    @(posedge MCLK);
    #1 chk(BUS_RDATA, exp);
    @(posedge MCLK);
    BUS_READ <= 1'b0;
    #1 chk(BUS_RDATA, exp);
    @(posedge MCLK);
  endtask

  // event pulses slow enough for the two-flop synchroniser
  task pulse(input int n);
    repeat (n)
    begin
      EVENT_COUNT_PIN <= 1'b1;
      repeat (5) @(posedge MCLK);
      EVENT_COUNT_PIN <= 1'b0;
      repeat (5) @(posedge MCLK);
    end
  endtask

  task irq_is(input logic exp);
    @(posedge MCLK);
    #1 chk({7'h00, OVERFLOW_IRQ}, {7'h00, exp});
    @(posedge MCLK);
  endtask

  task t_reset;
    rd(`ARIT_MODE_ADDR, 8'h78);
    rd(`ARIT_COUNT_ADDR, 8'h00);
    rd(`ARIT_IRQ_ADDR, 8'h00);
    rd(16'hFFB0, 8'h00);
  endtask

  task t_mode;
    for (int i = 0; i < 8; i++)
    begin
      wr_rd(`ARIT_MODE_ADDR, {i[0], 4'h0, i[2:0]}, {i[0], 4'hF, i[2:0]});
    end
  endtask

  // halting around the window means any prescaler phase gives exactly one tick
  task t_div;
    for (int i = 0; i < 7; i++)
    begin
      COUNT_HALT <= 1'b1;
      wr(`ARIT_MODE_ADDR, {5'h00, i[2:0]});
      wr_rd(`ARIT_COUNT_ADDR, 8'h00, 8'h00);
      COUNT_HALT <= 1'b0;
      repeat (dv[i]) @(posedge MCLK);
      COUNT_HALT <= 1'b1;
      @(posedge MCLK);
      rd2(`ARIT_COUNT_ADDR, 8'h01);
    end
    COUNT_HALT <= 1'b0;
  endtask

  // clock enable low freezes everything, even with the counter released
  task t_freeze;
    COUNT_HALT <= 1'b1;
    wr(`ARIT_MODE_ADDR, 8'h06);
    wr_rd(`ARIT_COUNT_ADDR, 8'h10, 8'h10);
    COUNT_HALT <= 1'b0;
    CLOCK_ENABLE <= 1'b0;
    repeat (40) @(posedge MCLK);
    COUNT_HALT <= 1'b1;
    CLOCK_ENABLE <= 1'b1;
    @(posedge MCLK);
    rd(`ARIT_COUNT_ADDR, 8'h10);
    COUNT_HALT <= 1'b0;
    @(posedge MCLK);
  endtask

  // the block has no event pin interrupt; nothing to disable here

  task t_event;
    wr(`ARIT_IRQ_ADDR, 8'h04);
    wr(`ARIT_MODE_ADDR, 8'h07);
    wr(`ARIT_COUNT_ADDR, 8'h00);
    pulse(3);
    rd(`ARIT_COUNT_ADDR, 8'h03);
    wr(`ARIT_IRQ_ADDR, 8'h00);
    wr(`ARIT_COUNT_ADDR, 8'h00);
    pulse(2);
    rd(`ARIT_COUNT_ADDR, 8'h02);
  endtask

  task t_ovf;
    wr(`ARIT_IRQ_ADDR, 8'h06);
    wr(`ARIT_COUNT_ADDR, 8'hFE);
    pulse(2);
    rd(`ARIT_COUNT_ADDR, 8'h00);
    rd(`ARIT_IRQ_ADDR, 8'h07);
    irq_is(1'b1);
    wr(`ARIT_IRQ_ADDR, 8'h06);
    irq_is(1'b0);
    wr(`ARIT_MODE_ADDR, 8'h87);
    wr(`ARIT_COUNT_ADDR, 8'hFF);
    pulse(1);
    rd(`ARIT_COUNT_ADDR, 8'hFF);
    wr(`ARIT_COUNT_ADDR, 8'hFD);
    pulse(3);
    rd(`ARIT_COUNT_ADDR, 8'hFD);
    wr(`ARIT_IRQ_ADDR, 8'h05);
    irq_is(1'b0);
    rd(`ARIT_IRQ_ADDR, 8'h05);
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge MCLK);
    mismatches++;
    summarize;
  end

  initial
  begin
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    t_reset;
    t_mode;
    t_div;
    t_freeze;
    t_event;
    t_ovf;
    summarize;
  end
endmodule // tb_arit_timer
